//--- pkg/rsc_cfg.svh
// Register indices, field positions and reset values of the readout bank
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RSC_IDX_REG_READOUT 8'h2C
`define RSC_IDX_STRENGTH 8'h2D
`define RSC_IDX_GAIN_CUT 8'h2E
`define RSC_IDX_SENSOR_CTRL 8'h2F
`define RSC_IDX_SENSOR_READOUT 8'h30
`define RSC_IDX_REG_CTRL 8'h40
`define RSC_IDX_IRQ_STATUS 8'h41
`define RSC_IDX_IRQ_MASK 8'h42
`define RSC_IDX_COMMAND 8'h43
`define RSC_IDX_GAIN_CFG 8'h44

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RSC_CODE_MSB 7
`define RSC_CODE_LSB 4
`define RSC_CLIM_BIT 0
`define RSC_TRIM_MSB 7
`define RSC_TRIM_LSB 3
`define RSC_GSEL_MSB 2
`define RSC_GSEL_LSB 0
`define RSC_CAL_END_BIT 2
`define RSC_CAL_ERR_BIT 1
`define RSC_REG_SRC_BIT 7
`define RSC_REG_EXT_MSB 6
`define RSC_REG_EXT_LSB 3
`define RSC_CMD_CLR_BIT 0
`define RSC_CMD_CAL_BIT 1
`define RSC_IRQ_ADJ_BIT 0
`define RSC_IRQ_CAL_END_BIT 1
`define RSC_IRQ_CAL_ERR_BIT 2
`define RSC_IRQ_CLIM_BIT 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RSC_SENSOR_CTRL_RST 8'h00
`define RSC_REG_CTRL_RST 8'h00
`define RSC_GAIN_CFG_RST 8'h00
`define RSC_IRQ_MASK_RST 4'h0
`define RSC_ADJ_CODE_RST 4'h0

`endif

//--- pkg/rsc_pkg.sv
// Types shared by the readout and sensor calibration bank
package rsc_pkg;

  // ----------------------------------------------------------------
  // Decoded sensor gain
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    GAIN_2P8,
    GAIN_6P5,
    GAIN_1P1,
    GAIN_0P5,
    GAIN_0P35,
    GAIN_UNUSED
  } rsc_gain_t;

  // ----------------------------------------------------------------
  // Channel pair, AM in the upper nibble
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] am;
    logic [3:0] pm;
  } rsc_pair_t;

  // ----------------------------------------------------------------
  // Calibration result from the sensor
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] trim;
    logic done;
    logic error;
  } rsc_cal_t;

endpackage : rsc_pkg

//--- src/rsc_gain_total.sv
// Total gain reduction of one receive channel
`timescale 1ns/100ps
module rsc_gain_total #(
  parameter int W = 4
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic [W-1:0] i_reg_cut,
  input wire logic [W-1:0] i_squelch_cut,
  input wire logic [W-1:0] i_agc_cut,
  output logic [W-1:0] o_total
);

  logic [W+1:0] sum;

  // ----------------------------------------------------------------
  // Saturating sum of the three contributions
  // ----------------------------------------------------------------
  always_comb begin
    sum = {2'b00, i_reg_cut} + {2'b00, i_squelch_cut}
        + {2'b00, i_agc_cut};
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_total <= '0;
    end else if (sum[W+1:W] != 2'b00) begin
      o_total <= '1;
    end else begin
      o_total <= sum[W-1:0];
    end
  end

endmodule : rsc_gain_total

//--- src/rsc_peak_hold.sv
// Peak hold of one signal strength channel
`timescale 1ns/100ps
module rsc_peak_hold #(
  parameter int W = 4
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_clear,
  input wire logic i_valid,
  input wire logic [W-1:0] i_sample,
  output logic [W-1:0] o_peak
);

  // ----------------------------------------------------------------
  // Peak register
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst || i_clear) begin
      o_peak <= '0;
    end else if (i_valid && (i_sample > o_peak)) begin
      o_peak <= i_sample;
    end
  end

endmodule : rsc_peak_hold

//--- src/rsc_regs.sv
// Readout and capacitive sensor calibration register bank on APB
//
// Behaviour
// - Regulator readout upper nibble shows last regulator-adjust result code
// - Regulator readout bit 0 reads 1 while supply is current limited
// - Source select set: regulated code comes from software-written code bits
// - Strength upper nibble holds AM peak until reception start or clear
// - Strength lower nibble holds PM peak until reception start or clear
// - Each strength nibble is a monotonic 4-bit level code, zero lowest
// - Gain readout upper nibble: AM register plus squelch plus AGC cut
// - Gain readout lower nibble: PM register plus squelch plus AGC cut
// - Sensor control bits 7..3 are binary weighted manual trim value
// - Trim zero selects automatic calibration, nonzero selects manual
// - Gain codes 000,001,010,100,110 decode to gains; others unused
// - Sensor readout: result bits 7..3, end flag bit 2, error bit 1
`timescale 1ns/100ps
`include "rsc_cfg.svh"
module rsc_regs #(
  parameter int AW = 10,
  parameter int LW = 4
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_adjust_done,
  input wire logic [3:0] i_adjust_code,
  input wire logic i_current_limit,
  output logic [3:0] o_reg_voltage_code,
  input wire logic i_rx_start,
  input wire logic i_sample_valid,
  input wire rsc_pkg::rsc_pair_t i_signal_sample,
  input wire rsc_pkg::rsc_pair_t i_squelch_cut,
  input wire rsc_pkg::rsc_pair_t i_agc_cut,
  output logic [4:0] o_sensor_manual_trim,
  output logic o_sensor_auto_cal,
  output rsc_pkg::rsc_gain_t o_sensor_gain,
  output logic o_cal_start,
  input wire logic i_cal_done,
  input wire rsc_pkg::rsc_cal_t i_cal_result,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] sensor_ctrl;
  logic [7:0] reg_ctrl;
  logic [7:0] gain_cfg;
  logic [3:0] adj_code;
  logic [4:0] trim_result;
  logic cal_end;
  logic cal_err;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic clim_prev;
  logic clear_strength;
  logic [7:0] peak_bits;
  logic [7:0] cut_bits;
  rsc_pkg::rsc_pair_t signal_peak;
  rsc_pkg::rsc_pair_t total_gain_cut;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic [7:0] idx;
  logic aligned;
  logic wr_en;
  logic [7:0] wbyte;
  logic mapped;
  logic [7:0] next_rdata;
  logic [3:0] next_irq_status;
  logic [3:0] irq_event;

  assign idx = i_paddr[9:2];
  assign aligned = (i_paddr[1:0] == 2'b00);
  assign wr_en = i_psel && i_penable && i_pwrite && i_pstrb[0] && mapped;
  assign wbyte = i_pwdata[7:0];
  assign o_pready = 1'b1;

  always_comb begin
    mapped = aligned;
    next_rdata = 8'h00;
    case (idx)
      `RSC_IDX_REG_READOUT: begin
        next_rdata = {adj_code, 3'b000, i_current_limit};
      end
      `RSC_IDX_STRENGTH: begin
        next_rdata = signal_peak;
      end
      `RSC_IDX_GAIN_CUT: begin
        next_rdata = total_gain_cut;
      end
      `RSC_IDX_SENSOR_CTRL: begin
        next_rdata = sensor_ctrl;
      end
      `RSC_IDX_SENSOR_READOUT: begin
        next_rdata = {trim_result, cal_end, cal_err, 1'b0};
      end
      `RSC_IDX_REG_CTRL: begin
        next_rdata = {reg_ctrl[7:3], 3'b000};
      end
      `RSC_IDX_IRQ_STATUS: begin
        next_rdata = {4'h0, irq_status};
      end
      `RSC_IDX_IRQ_MASK: begin
        next_rdata = {4'h0, irq_mask};
      end
      `RSC_IDX_COMMAND: begin
        next_rdata = 8'h00;
      end
      `RSC_IDX_GAIN_CFG: begin
        next_rdata = gain_cfg;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
    if (!aligned) begin
      next_rdata = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Read data and error, captured in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_psel && !i_penable) begin
      o_prdata <= {24'h00_0000, next_rdata};
      o_pslverr <= !mapped;
    end
  end

  // ----------------------------------------------------------------
  // Software control registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      sensor_ctrl <= `RSC_SENSOR_CTRL_RST;
      reg_ctrl <= `RSC_REG_CTRL_RST;
      gain_cfg <= `RSC_GAIN_CFG_RST;
      irq_mask <= `RSC_IRQ_MASK_RST;
    end else if (wr_en) begin
      case (idx)
        `RSC_IDX_SENSOR_CTRL: begin
          sensor_ctrl <= wbyte;
        end
        `RSC_IDX_REG_CTRL: begin
          reg_ctrl <= {wbyte[7:3], 3'b000};
        end
        `RSC_IDX_GAIN_CFG: begin
          gain_cfg <= wbyte;
        end
        `RSC_IDX_IRQ_MASK: begin
          irq_mask <= wbyte[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command pulses
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      clear_strength <= 1'b0;
      o_cal_start <= 1'b0;
    end else begin
      clear_strength <= wr_en && (idx == `RSC_IDX_COMMAND)
        && wbyte[`RSC_CMD_CLR_BIT];
      o_cal_start <= wr_en && (idx == `RSC_IDX_COMMAND)
        && wbyte[`RSC_CMD_CAL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Regulator
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      adj_code <= `RSC_ADJ_CODE_RST;
    end else if (i_adjust_done) begin
      adj_code <= i_adjust_code;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_reg_voltage_code <= `RSC_ADJ_CODE_RST;
    end else if (reg_ctrl[`RSC_REG_SRC_BIT]) begin
      o_reg_voltage_code <= reg_ctrl[`RSC_REG_EXT_MSB:`RSC_REG_EXT_LSB];
    end else begin
      o_reg_voltage_code <= adj_code;
    end
  end

  // ----------------------------------------------------------------
  // Per channel peak hold and gain total, index 1 is AM
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      rsc_peak_hold #(
        .W(LW)
      ) u_peak (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_clear(i_rx_start || clear_strength),
        .i_valid(i_sample_valid),
        .i_sample(i_signal_sample[4*ch +: 4]),
        .o_peak(peak_bits[4*ch +: 4])
      );
      rsc_gain_total #(
        .W(LW)
      ) u_gain (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_reg_cut(gain_cfg[4*ch +: 4]),
        .i_squelch_cut(i_squelch_cut[4*ch +: 4]),
        .i_agc_cut(i_agc_cut[4*ch +: 4]),
        .o_total(cut_bits[4*ch +: 4])
      );
    end
  endgenerate

  assign signal_peak = peak_bits;
  assign total_gain_cut = cut_bits;

  // ----------------------------------------------------------------
  // Capacitive sensor control
  // ----------------------------------------------------------------
  // trim field out
  assign o_sensor_manual_trim = sensor_ctrl[`RSC_TRIM_MSB:`RSC_TRIM_LSB];
  assign o_sensor_auto_cal = (o_sensor_manual_trim == 5'h00);

  always_comb begin
    case (sensor_ctrl[`RSC_GSEL_MSB:`RSC_GSEL_LSB])
      3'h0: o_sensor_gain = rsc_pkg::GAIN_2P8;
      3'h1: o_sensor_gain = rsc_pkg::GAIN_6P5;
      3'h2: o_sensor_gain = rsc_pkg::GAIN_1P1;
      3'h4: o_sensor_gain = rsc_pkg::GAIN_0P5;
      3'h6: o_sensor_gain = rsc_pkg::GAIN_0P35;
      default: o_sensor_gain = rsc_pkg::GAIN_UNUSED;
    endcase
  end

  // ----------------------------------------------------------------
  // Capacitive sensor readout
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      trim_result <= 5'h00;
      cal_end <= 1'b0;
      cal_err <= 1'b0;
    end else if (i_cal_done) begin
      trim_result <= i_cal_result.trim;
      cal_end <= 1'b1;
      cal_err <= i_cal_result.error;
    end else if (o_cal_start) begin
      cal_end <= 1'b0;
      cal_err <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      clim_prev <= 1'b0;
    end else begin
      clim_prev <= i_current_limit;
    end
  end

  always_comb begin
    irq_event = 4'h0;
    irq_event[`RSC_IRQ_ADJ_BIT] = i_adjust_done;
    irq_event[`RSC_IRQ_CAL_END_BIT] = i_cal_done;
    irq_event[`RSC_IRQ_CAL_ERR_BIT] = i_cal_done && i_cal_result.error;
    irq_event[`RSC_IRQ_CLIM_BIT] = i_current_limit && !clim_prev;
    next_irq_status = irq_status;
    if (wr_en && (idx == `RSC_IDX_IRQ_STATUS)) begin
      next_irq_status = irq_status & ~wbyte[3:0];
    end
    next_irq_status = next_irq_status | irq_event;
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      irq_status <= 4'h0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  assign o_irq = |(irq_status & irq_mask);

endmodule : rsc_regs

//--- tb/rsc_regs_props.sv
// Port checks for the readout register bank
`timescale 1ns/100ps
module rsc_regs_props #(
  parameter int AW = 10
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic i_current_limit,
  input wire logic [3:0] o_reg_voltage_code,
  input wire logic [4:0] o_sensor_manual_trim,
  input wire logic o_sensor_auto_cal,
  input wire rsc_pkg::rsc_gain_t o_sensor_gain,
  input wire logic o_cal_start
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);
  logic setup;
  logic wr;
  assign setup = i_psel && !i_penable;
  assign wr = i_psel && i_penable && i_pwrite && i_pstrb[0];

  function automatic rsc_pkg::rsc_gain_t dec(input logic [2:0] c);
    case (c)
      3'h0: return rsc_pkg::GAIN_2P8;
      3'h1: return rsc_pkg::GAIN_6P5;
      3'h2: return rsc_pkg::GAIN_1P1;
      3'h4: return rsc_pkg::GAIN_0P5;
      3'h6: return rsc_pkg::GAIN_0P35;
      default: return rsc_pkg::GAIN_UNUSED;
    endcase
  endfunction : dec

  property p_auto;
    o_sensor_auto_cal == (o_sensor_manual_trim == 5'h00);
  endproperty
  a_auto: assert property (p_auto) else $error("auto cal flag wrong");
  property p_trim;
    wr && i_paddr == 10'h0BC |=> o_sensor_manual_trim == $past(i_pwdata[7:3]);
  endproperty
  a_trim: assert property (p_trim) else $error("trim not written");
  property p_gain;
    wr && i_paddr == 10'h0BC |=> o_sensor_gain == dec($past(i_pwdata[2:0]));
  endproperty
  a_gain: assert property (p_gain) else $error("gain decode wrong");
  property p_clim;
    setup && !i_pwrite && i_paddr == 10'h0B0 && !$past(i_srst) &&
      $stable(i_current_limit) |=> o_prdata[0] == $past(i_current_limit);
  endproperty
  a_clim: assert property (p_clim) else $error("limit bit wrong");
  property p_src;
    wr && i_paddr == 10'h100 && i_pwdata[7]
      |-> ##2 o_reg_voltage_code == $past(i_pwdata[6:3], 2);
  endproperty
  a_src: assert property (p_src) else $error("ext code not used");
  property p_ro;
    setup && i_paddr inside {10'h0B0, 10'h0B4, 10'h0B8, 10'h0C0} |=> !o_pslverr;
  endproperty
  a_ro: assert property (p_ro) else $error("readout access error");
  property p_pulse;
    o_cal_start |=> !o_cal_start;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start too long");
  property p_cause;
    o_cal_start |-> $past(wr) && ($past(i_paddr) == 10'h10C)
      && $past(i_pwdata[1]);
  endproperty
  a_cause: assert property (p_cause) else $error("start uncaused");
endmodule : rsc_regs_props

bind rsc_regs rsc_regs_props #(.AW(AW)) i_props (
  .i_mclk(i_mclk), .i_srst(i_srst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
  .o_pslverr(o_pslverr), .i_current_limit(i_current_limit),
  .o_reg_voltage_code(o_reg_voltage_code),
  .o_sensor_manual_trim(o_sensor_manual_trim),
  .o_sensor_auto_cal(o_sensor_auto_cal), .o_sensor_gain(o_sensor_gain),
  .o_cal_start(o_cal_start)
);

//--- tb/rsc_regs_test.sv
// Self-checking bench of the readout register bank
`timescale 1ns/100ps
module rsc_regs_test;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [9:0] padr = 10'h000;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic rdy;
  logic err;
  logic adj = 1'b0;
  logic [3:0] adj_code = 4'h0;
  logic clim = 1'b0;
  logic rxs = 1'b0;
  logic sv = 1'b0;
  rsc_pkg::rsc_pair_t smp = 8'h00;
  rsc_pkg::rsc_pair_t sq = 8'h00;
  rsc_pkg::rsc_pair_t agc = 8'h00;
  logic [3:0] vcode;
  logic [4:0] trim;
  logic auto_cal;
  rsc_pkg::rsc_gain_t gain;
  logic cal_start;
  logic cal_done = 1'b0;
  rsc_pkg::rsc_cal_t cal_res = 7'h00;
  logic irq;
  logic [31:0] rd;
  logic er;
  int n_fail = 0;
  int tests_run = 0;
  int n_start = 0;
  rsc_pkg::rsc_gain_t eg [8] = '{rsc_pkg::GAIN_2P8, rsc_pkg::GAIN_6P5,
    rsc_pkg::GAIN_1P1, rsc_pkg::GAIN_UNUSED, rsc_pkg::GAIN_0P5,
    rsc_pkg::GAIN_UNUSED, rsc_pkg::GAIN_0P35, rsc_pkg::GAIN_UNUSED};

  always #4 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    if (cal_start === 1'b1) begin
      n_start <= n_start + 1;
    end
  end

  rsc_regs i_rsc_regs (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .i_pstrb(4'hF),
    .o_prdata(prd), .o_pready(rdy), .o_pslverr(err),
    .i_adjust_done(adj), .i_adjust_code(adj_code),
    .i_current_limit(clim), .o_reg_voltage_code(vcode),
    .i_rx_start(rxs), .i_sample_valid(sv), .i_signal_sample(smp),
    .i_squelch_cut(sq), .i_agc_cut(agc), .o_sensor_manual_trim(trim),
    .o_sensor_auto_cal(auto_cal), .o_sensor_gain(gain),
    .o_cal_start(cal_start), .i_cal_done(cal_done),
    .i_cal_result(cal_res), .o_irq(irq)
  );

  // ------
  // Shared tasks
  // ------
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk

  task automatic apb(input logic [7:0] idx, input logic w, input logic [7:0] d);
    int k;
    psel <= 1'b1;
    pwr <= w;
    padr <= {idx, 2'b00};
    pwd <= {24'h0, d};
    @(posedge i_mclk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge i_mclk);
      k++;
    end while (rdy !== 1'b1 && k < 16);
    if (rdy !== 1'b1) begin
      $display("[ERR] pready expected 1 seen %b", rdy);
      n_fail++;
      tally_and_finish;
    end
    rd = prd;
    er = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge i_mclk);
  endtask : apb

  task automatic rdchk(input string nm, input logic [7:0] idx,
                       input logic [31:0] e);
    apb(idx, 1'b0, 8'h00);
    chk(nm, e, rd);
  endtask : rdchk

  // ------
  // Scenarios
  // ------
  task automatic t_reset;
    chk("trim", 0, trim);
    chk("auto", 1, auto_cal);
    chk("gain", 0, gain);
    chk("irq", 0, irq);
    rdchk("ctrl", 8'h2F, 0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_sensor;
    logic [4:0] t;
    for (int c = 0; c < 8; c++) begin
      t = 5'(c * 5);
      apb(8'h2F, 1'b1, {t, 3'(c)});
      chk("trim", t, trim);
      chk("auto", t == 5'h00, auto_cal);
      chk("gain", eg[c], gain);
      rdchk("ctrl", 8'h2F, {t, 3'(c)});
    end
    $display("test sensor done");
  endtask : t_sensor

  task automatic t_reg;
    clim <= 1'b1;
    adj <= 1'b1;
    adj_code <= 4'hA;
    @(posedge i_mclk);
    adj <= 1'b0;
    repeat (2) @(posedge i_mclk);
    chk("vcode", 4'hA, vcode);
    rdchk("regread", 8'h2C, 8'hA1);
    apb(8'h2C, 1'b1, 8'hFF);
    rdchk("regro", 8'h2C, 8'hA1);
    apb(8'h40, 1'b1, 8'hA8);
    @(posedge i_mclk);
    chk("vcode", 4'h5, vcode);
    rdchk("regkeep", 8'h2C, 8'hA1);
    clim <= 1'b0;
    apb(8'h40, 1'b1, 8'h00);
    @(posedge i_mclk);
    chk("vcode", 4'hA, vcode);
    rdchk("regclim", 8'h2C, 8'hA0);
    $display("test regulator done");
  endtask : t_reg

  task automatic t_strength;
    sv <= 1'b1;
    smp <= 8'h37;
    @(posedge i_mclk);
    smp <= 8'h29;
    @(posedge i_mclk);
    smp <= 8'h18;
    @(posedge i_mclk);
    sv <= 1'b0;
    rdchk("peak", 8'h2D, 8'h39);
    rxs <= 1'b1;
    @(posedge i_mclk);
    rxs <= 1'b0;
    rdchk("rxclr", 8'h2D, 8'h00);
    sv <= 1'b1;
    smp <= 8'hF1;
    @(posedge i_mclk);
    sv <= 1'b0;
    rdchk("top", 8'h2D, 8'hF1);
    apb(8'h43, 1'b1, 8'h01);
    @(posedge i_mclk);
    rdchk("cmdclr", 8'h2D, 8'h00);
    $display("test strength done");
  endtask : t_strength

  task automatic t_gain;
    apb(8'h44, 1'b1, 8'h21);
    sq <= 8'h12;
    agc <= 8'h11;
    repeat (2) @(posedge i_mclk);
    rdchk("cut", 8'h2E, 8'h44);
    agc <= 8'hF0;
    repeat (2) @(posedge i_mclk);
    rdchk("cutsat", 8'h2E, 8'hF3);
    $display("test gain done");
  endtask : t_gain

  task automatic t_cal;
    rdchk("stat", 8'h41, 8'h09);
    apb(8'h41, 1'b1, 8'h0F);
    rdchk("stat", 8'h41, 0);
    apb(8'h43, 1'b1, 8'h02);
    @(posedge i_mclk);
    chk("starts", 1, n_start);
    apb(8'h42, 1'b1, 8'h02);
    cal_res <= 7'h4D;
    cal_done <= 1'b1;
    @(posedge i_mclk);
    cal_done <= 1'b0;
    repeat (2) @(posedge i_mclk);
    chk("irq", 1, irq);
    rdchk("calread", 8'h30, 8'h9E);
    rdchk("stat", 8'h41, 8'h06);
    apb(8'h41, 1'b1, 8'h02);
    @(posedge i_mclk);
    chk("irq", 0, irq);
    rdchk("stat", 8'h41, 8'h04);
    apb(8'h43, 1'b1, 8'h02);
    @(posedge i_mclk);
    rdchk("calclr", 8'h30, 8'h98);
    apb(8'h3C, 1'b0, 8'h00);
    chk("slverr", 1, er);
    chk("errdata", 0, rd);
    $display("test calibration done");
  endtask : t_cal

  initial begin
    repeat (12) @(posedge i_mclk);
    i_srst <= 1'b0;
    @(posedge i_mclk);
    t_reset;
    t_sensor;
    t_reg;
    t_strength;
    t_gain;
    t_cal;
    tally_and_finish;
  end
endmodule : rsc_regs_test
